// [rtl/tsa_axil_slave.sv]
// AXI4-Lite slave turning bus transfers into one-cycle register strobes.
// Assumes one write and one read outstanding at most; index is addr[15:2].
module tsa_axil_slave (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Write channels
   input  wire logic [15:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // Read channels
   input  wire logic [15:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Register side
   tsa_reg_if.bus           rif
);

   logic        aw_held_r;
   logic        w_held_r;
   logic        ar_held_r;
   logic        wr_stb_r;
   logic        rd_stb_r;
   logic [13:0] aw_idx_r;
   logic [13:0] ar_idx_r;
   logic [15:0] wdata_r;
   logic [1:0]  wstrb_r;

   assign rif.wr_stb = wr_stb_r;
   assign rif.wr_idx = aw_idx_r;
   assign rif.wdata  = wdata_r;
   assign rif.wstrb  = wstrb_r;
   assign rif.rd_stb = rd_stb_r;
   assign rif.rd_idx = ar_idx_r;

   // ===========================================================
   // Write address, held until the response is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         awready   <= 1'b0;
         aw_idx_r  <= 14'h0000;
      end else if (awvalid && awready) begin
         aw_held_r <= 1'b1;
         awready   <= 1'b0;
         aw_idx_r  <= awaddr[15:2];
      end else if (bvalid && bready) begin
         aw_held_r <= 1'b0;
         awready   <= 1'b1;
      end else if (!aw_held_r) begin
         awready   <= 1'b1;
      end
   end

   // Write data, only the two low byte lanes carry register bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_r <= 1'b0;
         wready   <= 1'b0;
         wdata_r  <= 16'h0000;
         wstrb_r  <= 2'h0;
      end else if (wvalid && wready) begin
         w_held_r <= 1'b1;
         wready   <= 1'b0;
         wdata_r  <= wdata[15:0];
         wstrb_r  <= wstrb[1:0];
      end else if (bvalid && bready) begin
         w_held_r <= 1'b0;
         wready   <= 1'b1;
      end else if (!w_held_r) begin
         wready   <= 1'b1;
      end
   end

   // Write strobe once both halves are in, then the response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_stb_r <= 1'b0;
         bvalid   <= 1'b0;
         bresp    <= tsa_pkg::RESP_OKAY;
      end else begin
         wr_stb_r <= aw_held_r && w_held_r && !wr_stb_r && !bvalid;
         if (wr_stb_r) begin
            bvalid <= 1'b1;
            bresp  <= rif.wr_hit ? tsa_pkg::RESP_OKAY : tsa_pkg::RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // ===========================================================
   // Read address, strobe and registered data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ar_held_r <= 1'b0;
         arready   <= 1'b0;
         ar_idx_r  <= 14'h0000;
      end else if (arvalid && arready) begin
         ar_held_r <= 1'b1;
         arready   <= 1'b0;
         ar_idx_r  <= araddr[15:2];
      end else if (rvalid && rready) begin
         ar_held_r <= 1'b0;
         arready   <= 1'b1;
      end else if (!ar_held_r) begin
         arready   <= 1'b1;
      end
   end

   // Data captured at the same edge as any clear-on-read side effect
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_stb_r <= 1'b0;
         rvalid   <= 1'b0;
         rresp    <= tsa_pkg::RESP_OKAY;
         rdata    <= 32'h00000000;
      end else begin
         rd_stb_r <= ar_held_r && !rd_stb_r && !rvalid;
         if (rd_stb_r) begin
            rvalid <= 1'b1;
            rresp  <= rif.rd_hit ? tsa_pkg::RESP_OKAY : tsa_pkg::RESP_SLVERR;
            rdata  <= {16'h0000, rif.rdata};
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end

endmodule

// [rtl/tsa_pkg.sv]
// Package for the transmit analog front-end control registers.
// Assumes a 10 MHz register clock and 16-bit registers on a 32-bit bus.
package tsa_pkg;

   // ===========================================================
   // Register indices (byte address is four times the index)
   localparam logic [13:0] IDX_ANALOG_CS  = 14'h1020;
   localparam logic [13:0] IDX_SYNTH_PWR  = 14'h1021;
   localparam logic [13:0] IDX_MISC_CTRL  = 14'h1022;
   localparam logic [13:0] IDX_QUAD_SYNTH = 14'h1030;

   // ===========================================================
   // Reset values and writable masks
   localparam logic [15:0] ANALOG_CS_RST  = 16'h0800;
   localparam logic [15:0] ANALOG_CS_WM   = 16'h09FD;
   localparam logic [15:0] SYNTH_PWR_RST  = 16'h1E68;
   localparam logic [15:0] SYNTH_PWR_WM   = 16'hFFFF;
   localparam logic [15:0] MISC_CTRL_RST  = 16'h0000;
   localparam logic [15:0] MISC_CTRL_WM   = 16'h0007;
   localparam logic [15:0] QUAD_SYNTH_RST = 16'h0701;
   localparam logic [15:0] QUAD_SYNTH_WM  = 16'hFFFF;

   // ===========================================================
   // Field positions, analog control/status
   localparam int unsigned B_LOCK_IRQ_EN  = 0;
   localparam int unsigned B_LOCK_NOW     = 1;
   localparam int unsigned B_POL_INV      = 2;
   localparam int unsigned B_LOOPBACK     = 3;
   localparam int unsigned B_MODE_LO      = 6;
   localparam int unsigned B_ACTIVITY     = 14;
   localparam int unsigned B_LOCK_LATCHED = 15;
   // Field positions, synthesizer power/reset
   localparam int unsigned B_LOOP_TIME_N  = 7;
   localparam int unsigned B_PWR_LO       = 9;
   localparam int unsigned B_SYNTH_RST    = 13;
   localparam int unsigned B_SER_RST      = 14;
   // Field positions, misc control
   localparam int unsigned B_WCM          = 0;
   localparam int unsigned B_WCM_SINGLE   = 1;
   localparam int unsigned B_RECOVERED_CLOCK_SEL   = 2;
   localparam int unsigned B_RELOCKING    = 8;
   localparam int unsigned B_MODE_RSVD    = 9;
   // Field position, quad synthesizer
   localparam int unsigned B_QUAD_RST_N   = 0;

   // ===========================================================
   // Timing
   localparam int unsigned CLK_PERIOD_NS  = 100;
   localparam int unsigned QRST_MIN_NS    = 100;
   localparam int unsigned QRST_MIN_CYC   = (QRST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RELOCK_MS      = 5;
   localparam int unsigned RELOCK_CYC     = RELOCK_MS * 1000000 / CLK_PERIOD_NS;

   // ===========================================================
   // Bus responses
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

endpackage

// [rtl/tsa_reg_if.sv]
// Register access strobes between the bus slave and the register bank.
// Assumes both ends run on the same clock.
interface tsa_reg_if;
   logic        wr_stb;
   logic [13:0] wr_idx;
   logic [15:0] wdata;
   logic [1:0]  wstrb;
   logic        wr_hit;
   logic        rd_stb;
   logic [13:0] rd_idx;
   logic [15:0] rdata;
   logic        rd_hit;

   modport bus  (output wr_stb, wr_idx, wdata, wstrb, rd_stb, rd_idx,
                 input  wr_hit, rd_hit, rdata);
   modport regs (input  wr_stb, wr_idx, wdata, wstrb, rd_stb, rd_idx,
                 output wr_hit, rd_hit, rdata);
endinterface

// [rtl/tsa_tx_analog_regs.sv]
// Transmit analog front-end control and status register bank.
// Assumes comparator, reference clock and data inputs synchronous to aclk.
module tsa_tx_analog_regs #(
   parameter int unsigned RELOCK_CYC = tsa_pkg::RELOCK_CYC
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write channels
   input  wire logic [15:0] awaddr,
   input  wire logic [2:0]  awprot,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // AXI4-Lite read channels
   input  wire logic [15:0] araddr,
   input  wire logic [2:0]  arprot,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Monitors from the analog blocks
   input  wire logic        freq_cmp_out_of_lock,
   input  wire logic        refclk_level,
   // Transmit data sources
   input  wire logic        tx_proc_data,
   input  wire logic        rx_recovered_data,
   input  wire logic        quad_ch1_data,
   // Transmit path controls
   output logic             tx_line_data,
   output logic             serializer_clk_from_rx,
   output logic             tx_src_quad_ch1,
   output logic             tx_swing_limited,
   output logic [1:0]       quad_ch1_swing,
   output logic             synth_ref_from_rx,
   output logic             recovered_clock_sel,
   // Power and reset controls
   output logic [3:0]       block_power_en,
   output logic             synth_pll_reset,
   output logic             serializer_reset,
   output logic             quad_synth_reset_n,
   // Interrupt
   output logic             interrupt_out_n
);

   tsa_reg_if rif ();

   logic [15:0] analog_cs_r;
   logic [15:0] synth_pwr_r;
   logic [15:0] misc_ctrl_r;
   logic [15:0] quad_synth_r;
   logic        ref_lock_loss_latched;
   logic        refclk_activity_seen;
   logic        refclk_prev_r;
   logic [15:0] qrst_cnt_r;
   logic [15:0] relock_cnt_r;
   logic        analog_rd;
   logic        analog_wr;
   logic [15:0] lane_mask;
   logic        wc_write_mode;
   logic [2:0]  tx_serial_mode_sel;
   logic        mode_reserved;
   logic        tx_sel_data;

   // ===========================================================
   // Bus slave
   tsa_axil_slave u_slave (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .rif     (rif)
   );

   // ===========================================================
   // Decode helpers
   assign lane_mask     = {{8{rif.wstrb[1]}}, {8{rif.wstrb[0]}}};
   assign analog_rd     = rif.rd_stb && (rif.rd_idx == tsa_pkg::IDX_ANALOG_CS);
   assign analog_wr     = rif.wr_stb && (rif.wr_idx == tsa_pkg::IDX_ANALOG_CS);
   assign wc_write_mode = misc_ctrl_r[tsa_pkg::B_WCM] ^ misc_ctrl_r[tsa_pkg::B_WCM_SINGLE];
   assign tx_serial_mode_sel = analog_cs_r[tsa_pkg::B_MODE_LO +: 3];
   assign mode_reserved = tx_serial_mode_sel[1] || (tx_serial_mode_sel == 3'h7);

   // Mapped indices answer OKAY, all others SLVERR
   always_comb begin
      rif.wr_hit = (rif.wr_idx == tsa_pkg::IDX_ANALOG_CS)
                || (rif.wr_idx == tsa_pkg::IDX_SYNTH_PWR)
                || (rif.wr_idx == tsa_pkg::IDX_MISC_CTRL)
                || (rif.wr_idx == tsa_pkg::IDX_QUAD_SYNTH);
      rif.rd_hit = (rif.rd_idx == tsa_pkg::IDX_ANALOG_CS)
                || (rif.rd_idx == tsa_pkg::IDX_SYNTH_PWR)
                || (rif.rd_idx == tsa_pkg::IDX_MISC_CTRL)
                || (rif.rd_idx == tsa_pkg::IDX_QUAD_SYNTH);
   end

   // ===========================================================
   // Read data mux, unmapped indices give zero; reserved bits read zero except at the two all-ones-mask indices
   always_comb begin
      rif.rdata = 16'h0000;
      case (rif.rd_idx)
         tsa_pkg::IDX_ANALOG_CS: begin
            rif.rdata = analog_cs_r & tsa_pkg::ANALOG_CS_WM;
            rif.rdata[tsa_pkg::B_LOCK_LATCHED] = ref_lock_loss_latched;
            rif.rdata[tsa_pkg::B_ACTIVITY]     = refclk_activity_seen;
            rif.rdata[tsa_pkg::B_LOCK_NOW]     = freq_cmp_out_of_lock;
         end
         tsa_pkg::IDX_SYNTH_PWR:  rif.rdata = synth_pwr_r;
         tsa_pkg::IDX_MISC_CTRL: begin
            rif.rdata = misc_ctrl_r & tsa_pkg::MISC_CTRL_WM;
            rif.rdata[tsa_pkg::B_RELOCKING] = (relock_cnt_r != 16'h0000);
            rif.rdata[tsa_pkg::B_MODE_RSVD] = mode_reserved;
         end
         tsa_pkg::IDX_QUAD_SYNTH: rif.rdata = quad_synth_r;
         default:                 rif.rdata = 16'h0000;
      endcase
   end

   // ===========================================================
   // Writable storage, only writable bits and enabled lanes change
   // reserved bits stored as written only at the two all-ones-mask indices, elsewhere they keep the reset value
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         analog_cs_r  <= tsa_pkg::ANALOG_CS_RST;
         synth_pwr_r  <= tsa_pkg::SYNTH_PWR_RST;
         misc_ctrl_r  <= tsa_pkg::MISC_CTRL_RST;
         quad_synth_r <= tsa_pkg::QUAD_SYNTH_RST;
      end else if (rif.wr_stb) begin
         case (rif.wr_idx)
            tsa_pkg::IDX_ANALOG_CS: begin
               analog_cs_r <= (analog_cs_r & ~(lane_mask & tsa_pkg::ANALOG_CS_WM))
                            | (rif.wdata & lane_mask & tsa_pkg::ANALOG_CS_WM);
            end
            tsa_pkg::IDX_SYNTH_PWR: begin
               synth_pwr_r <= (synth_pwr_r & ~(lane_mask & tsa_pkg::SYNTH_PWR_WM))
                            | (rif.wdata & lane_mask & tsa_pkg::SYNTH_PWR_WM);
            end
            tsa_pkg::IDX_MISC_CTRL: begin
               misc_ctrl_r <= (misc_ctrl_r & ~(lane_mask & tsa_pkg::MISC_CTRL_WM))
                            | (rif.wdata & lane_mask & tsa_pkg::MISC_CTRL_WM);
            end
            tsa_pkg::IDX_QUAD_SYNTH: begin
               quad_synth_r <= (quad_synth_r & ~(lane_mask & tsa_pkg::QUAD_SYNTH_WM))
                             | (rif.wdata & lane_mask & tsa_pkg::QUAD_SYNTH_WM);
            end
            default: begin
               analog_cs_r <= analog_cs_r;
            end
         endcase
      end
   end

   // ===========================================================
   // Latched lock-loss event; a new event beats a clear
   // latch on failure
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ref_lock_loss_latched <= 1'b0;
      end else if (freq_cmp_out_of_lock) begin
         ref_lock_loss_latched <= 1'b1;
      end else if (wc_write_mode && analog_wr && rif.wstrb[1]
                   && rif.wdata[tsa_pkg::B_LOCK_LATCHED]) begin
         ref_lock_loss_latched <= 1'b0;
      end else if (!wc_write_mode && analog_rd) begin
         ref_lock_loss_latched <= 1'b0;
      end
   end

   // ===========================================================
   // Reference clock activity; edge seen in the read cycle survives
   // edge sets, read clears
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         refclk_prev_r        <= 1'b0;
         refclk_activity_seen <= 1'b1;
      end else begin
         refclk_prev_r <= refclk_level;
         if (refclk_level && !refclk_prev_r) begin
            refclk_activity_seen <= 1'b1;
         end else if (analog_rd) begin
            refclk_activity_seen <= 1'b0;
         end
      end
   end

   // ===========================================================
   // Quad synthesizer reset: stretched to the minimum, then relock
   // minimum low time and relock wait
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         qrst_cnt_r         <= 16'h0000;
         relock_cnt_r       <= 16'h0000;
         quad_synth_reset_n <= 1'b1;
      end else if (!quad_synth_r[tsa_pkg::B_QUAD_RST_N] && quad_synth_reset_n) begin
         quad_synth_reset_n <= 1'b0;
         qrst_cnt_r         <= 16'(tsa_pkg::QRST_MIN_CYC - 1);
         relock_cnt_r       <= 16'h0000;
      end else if (!quad_synth_reset_n) begin
         if (qrst_cnt_r != 16'h0000) begin
            qrst_cnt_r <= qrst_cnt_r - 16'h0001;
         end else if (quad_synth_r[tsa_pkg::B_QUAD_RST_N]) begin
            quad_synth_reset_n <= 1'b1;
            relock_cnt_r       <= 16'(RELOCK_CYC);
         end
      end else if (relock_cnt_r != 16'h0000) begin
         relock_cnt_r <= relock_cnt_r - 16'h0001;
      end
   end

   // ===========================================================
   // Transmit data path, one register stage to the line
   // source select; reserved 111 keeps the serializer
   always_comb begin
      if (tx_serial_mode_sel[2] && (tx_serial_mode_sel != 3'h7)) begin
         tx_sel_data = quad_ch1_data;
      end else if (analog_cs_r[tsa_pkg::B_LOOPBACK]) begin
         tx_sel_data = rx_recovered_data;
      end else begin
         tx_sel_data = tx_proc_data;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_line_data <= 1'b0;
      end else begin
         tx_line_data <= tx_sel_data ^ analog_cs_r[tsa_pkg::B_POL_INV];
      end
   end

   // ===========================================================
   // Control outputs, registered copies of the fields
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serializer_clk_from_rx <= 1'b0;
         tx_src_quad_ch1        <= 1'b0;
         tx_swing_limited       <= 1'b0;
         quad_ch1_swing         <= 2'h0;
         synth_ref_from_rx      <= 1'b1;
         recovered_clock_sel    <= 1'b0;
      end else begin
         serializer_clk_from_rx <= analog_cs_r[tsa_pkg::B_LOOPBACK];
         // reserved full code keeps serializer source
         tx_src_quad_ch1        <= tx_serial_mode_sel[2] && !(tx_serial_mode_sel == 3'h7);
         // swing; reserved codes fall back to full swing
         tx_swing_limited       <= (tx_serial_mode_sel[1:0] == 2'h1);
         quad_ch1_swing         <= tx_serial_mode_sel[1:0];
         synth_ref_from_rx      <= !synth_pwr_r[tsa_pkg::B_LOOP_TIME_N];
         recovered_clock_sel    <= misc_ctrl_r[tsa_pkg::B_RECOVERED_CLOCK_SEL];
      end
   end

   // Power enables and level resets; nothing here self-clears
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         block_power_en   <= 4'hF;
         synth_pll_reset  <= 1'b0;
         serializer_reset <= 1'b0;
      end else begin
         block_power_en   <= synth_pwr_r[tsa_pkg::B_PWR_LO +: 4];
         synth_pll_reset  <= synth_pwr_r[tsa_pkg::B_SYNTH_RST];
         serializer_reset <= synth_pwr_r[tsa_pkg::B_SER_RST];
      end
   end

   // ===========================================================
   // Interrupt, active-low level
   // enable gates latched bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         interrupt_out_n <= 1'b1;
      end else begin
         interrupt_out_n <= !(ref_lock_loss_latched && analog_cs_r[tsa_pkg::B_LOCK_IRQ_EN]);
      end
   end

endmodule

// [tb/testbench.sv]
// Self-checking bench for the transmit analog register bank.
// Drives AXI4-Lite and the analog monitor inputs directly.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic freq_cmp_out_of_lock = 0, refclk_level = 0;
   logic tx_proc_data = 0, rx_recovered_data = 0, quad_ch1_data = 0;
   logic awready, wready, bvalid, arready, rvalid, tx_line_data, serializer_clk_from_rx;
   logic tx_src_quad_ch1, tx_swing_limited, synth_ref_from_rx, recovered_clock_sel;
   logic synth_pll_reset, serializer_reset, quad_synth_reset_n, interrupt_out_n;
   logic [15:0] awaddr = '0, araddr = '0, v;
   logic [31:0] wdata = '0, rdata, rd_d, r;
   logic [2:0]  awprot = '0, arprot = '0;
   logic [3:0]  wstrb = 4'hF, block_power_en;
   logic [1:0]  bresp, rresp, quad_ch1_swing;
   logic [4:0]  e;
   integer      seed = 95, n_errors = 0, tests_run = 0, m;
   logic [13:0] ri [4] = '{14'h1020, 14'h1021, 14'h1022, 14'h1030};
   logic [15:0] rv [4] = '{16'h4800, 16'h1E68, 16'h0000, 16'h0701};
   // Short relock count keeps the run brief
   tsa_tx_analog_regs #(.RELOCK_CYC(20)) DUT (.*);
   always #50 aclk = ~aclk;
   // ==========================================
   // Bus tasks and expectations
   task chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task wr(input logic [13:0] i, input logic [15:0] d);
      logic a, w;
      {a, w} = 2'h3;
      awaddr <= {i, 2'h0};
      wdata <= {16'h0, d};
      {awvalid, wvalid} <= 2'h3;
      while (a | w) begin
         @(posedge aclk);
         if (a && awready) begin a = 0; awvalid <= 0; end
         if (w && wready) begin w = 0; wvalid <= 0; end
      end
      bready <= 1;
      do @(posedge aclk); while (!bvalid);
      bready <= 0;
   endtask
   // Read stalls rready until data shows, to exercise holding
   task rd(input logic [13:0] i);
      araddr <= {i, 2'h0};
      arvalid <= 1;
      do @(posedge aclk); while (!arready);
      arvalid <= 0;
      do @(posedge aclk); while (!rvalid);
      rready <= 1;
      @(posedge aclk);
      rready <= 0;
      rd_d = {rdata[31:18], rresp, rdata[15:0]};
   endtask
   task pulse_lock;
      freq_cmp_out_of_lock <= 1;
      @(posedge aclk);
      freq_cmp_out_of_lock <= 0;
      repeat (2) @(posedge aclk);
   endtask
   function logic [4:0] exp_mode(input logic [15:0] c);
      return {c[8] && c[8:6] != 3'h7, c[7:6] == 2'h1, c[7:6], c[3]};
   endfunction
   task final_report;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Watchdog, well beyond the five thousand four hundred or so cycles needed
   initial begin
      #2000000;
      n_errors++;
      final_report;
   end
   // ==========================================
   // Main sequence
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      for (m = 0; m < 4; m++) begin rd(ri[m]); chk(rd_d, {16'h0, rv[m]}); end
      chk({block_power_en, synth_ref_from_rx, quad_synth_reset_n}, 6'h3F);
      rd(14'h1020);
      chk(rd_d & 32'h4000, 0);
      refclk_level <= 1;
      @(posedge aclk);
      refclk_level <= 0;
      rd(14'h1020);
      chk(rd_d & 32'h4000, 32'h4000);
      rd(14'h1023);
      chk(rd_d, {14'h0, tsa_pkg::RESP_SLVERR, 16'h0});
      wr(14'h1023, 16'hFFFF);
      chk(bresp, tsa_pkg::RESP_SLVERR);
      $display("reset and monitor test done");
      wr(14'h1020, 16'h0801);
      pulse_lock;
      chk(interrupt_out_n, 0);
      freq_cmp_out_of_lock <= 1;
      rd(14'h1020);
      freq_cmp_out_of_lock <= 0;
      chk(rd_d & 32'h8003, 32'h8003);
      rd(14'h1020);
      chk(rd_d & 32'h8003, 32'h8001);
      repeat (2) @(posedge aclk);
      chk(interrupt_out_n, 1);
      wr(14'h1022, 16'h0006);
      pulse_lock;
      rd(14'h1020);
      rd(14'h1020);
      chk({rd_d[15], interrupt_out_n, recovered_clock_sel}, 3'h5);
      wr(14'h1020, 16'h8801);
      repeat (2) @(posedge aclk);
      chk(interrupt_out_n, 1);
      wr(14'h1020, 16'h0800);
      pulse_lock;
      chk(interrupt_out_n, 1);
      $display("lock loss test done");
      for (m = 0; m < 8; m++) begin
         r = $random(seed);
         v = {5'h1, 2'h0, m[2:0], 2'h0, r[3:2], 2'h0};
         wr(14'h1020, v);
         e = exp_mode(v);
         repeat (2) @(posedge aclk);
         chk({tx_src_quad_ch1, tx_swing_limited, quad_ch1_swing, serializer_clk_from_rx},
             e);
         repeat (6) begin
            r = $random(seed);
            {tx_proc_data, rx_recovered_data, quad_ch1_data} <= r[2:0];
            repeat (2) @(posedge aclk);
            chk(tx_line_data, (e[4] ? quad_ch1_data : v[3] ? rx_recovered_data
                : tx_proc_data) ^ v[2]);
         end
      end
      $display("data path test done");
      // Loopback off before loop-timing select moves
      wr(14'h1020, 16'h0800);
      repeat (6) begin
         r = $random(seed);
         // Reserved bits keep their defaults
         v = (r[15:0] & 16'h7E80) | 16'h0068;
         wr(14'h1021, v);
         repeat (3) @(posedge aclk);
         chk({block_power_en, synth_pll_reset, serializer_reset, synth_ref_from_rx},
             {v[12:9], v[13], v[14], ~v[7]});
         rd(14'h1021);
         chk(rd_d, {16'h0, v});
      end
      wr(14'h1021, 16'h3E68);
      repeat (2) @(posedge aclk);
      chk(synth_pll_reset, 32'h1);
      wr(14'h1021, 16'h1E68);
      repeat (2) @(posedge aclk);
      chk(synth_pll_reset, 32'h0);
      wr(14'h1020, 16'h8800);
      rd(14'h1020);
      repeat (5000) @(posedge aclk);
      rd(14'h1020);
      chk(rd_d & 32'h8000, 32'h0);
      wr(14'h1030, 16'h0700);
      repeat (2) @(posedge aclk);
      chk(quad_synth_reset_n, 0);
      wr(14'h1030, 16'h0701);
      rd(14'h1022);
      chk({rd_d[30:0], quad_synth_reset_n}, {31'h0106, 1'b1});
      repeat (30) @(posedge aclk);
      rd(14'h1022);
      chk(rd_d, 32'h0006);
      $display("power and reset test done");
      final_report;
   end
endmodule
bind tsa_tx_analog_regs tsa_chk u_chk (.*);

// [tb/tsa_chk.sv]
// Port checker for the transmit analog register bank.
// Bound to the top module; one clock domain, synchronous reset.
module tsa_chk (
   // Bus handshakes
   input wire logic        aclk, aresetn, awvalid, awready, wvalid, wready,
   input wire logic        bvalid, arvalid, arready, rvalid, rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp, quad_ch1_swing,
   // Front-end controls
   input wire logic        freq_cmp_out_of_lock, tx_swing_limited,
   input wire logic        quad_synth_reset_n, interrupt_out_n
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========================================
   // Bus timing, answer three edges after a take
   property p_wl;
      awvalid && awready && wvalid && wready |-> ##1 !awready ##1 !bvalid ##1 bvalid;
   endproperty
   a_wl: assert property (p_wl) else $error("write answer late or early");
   property p_rl;
      arvalid && arready |-> ##1 !arready ##1 !rvalid ##1 rvalid;
   endproperty
   a_rl: assert property (p_rl) else $error("read answer late or early");
   property p_rh;
      rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
   endproperty
   a_rh: assert property (p_rh) else $error("read data not held");
   property p_re;
      rvalid && rresp == tsa_pkg::RESP_SLVERR |-> rdata == 32'h0;
   endproperty
   a_re: assert property (p_re) else $error("error read not zero");
   // ==========================================
   // Front-end outputs
   property p_sw;
      tx_swing_limited == (quad_ch1_swing == 2'h1);
   endproperty
   a_sw: assert property (p_sw) else $error("swing outputs disagree");
   // Interrupt only falls after a lock event or a register write
   property p_if;
      $fell(interrupt_out_n) |-> $past(freq_cmp_out_of_lock, 2) || $past(bvalid);
   endproperty
   a_if: assert property (p_if) else $error("interrupt without cause");
   property p_ir;
      $rose(interrupt_out_n) |-> $past(rvalid) || $past(bvalid);
   endproperty
   a_ir: assert property (p_ir) else $error("interrupt released alone");
   property p_qr;
      $fell(quad_synth_reset_n) |=> !quad_synth_reset_n;
   endproperty
   a_qr: assert property (p_qr) else $error("quad reset too short");
endmodule
